/* verilog/rwp_pkg.sv */
// Package for the register write-protection lock block.
// Assumes a 32-bit AXI4-Lite register bus and a system bus write monitor.
package rwp_pkg;

  // Lock register offset within the system control block.
  localparam logic [11:0] RWP_UNLOCK_OFS    = 12'h100;
  localparam logic [31:0] RWP_UNLOCK_RESET  = 32'h0000_0000;
  localparam int          RWP_FLAG_BIT      = 0;

  // Key bytes, in the order they must be written.
  localparam logic [7:0]  RWP_KEY0          = 8'h59;
  localparam logic [7:0]  RWP_KEY1          = 8'h16;
  localparam logic [7:0]  RWP_KEY2          = 8'h88;

  // Full system addresses of the lock register and the guarded registers.
  localparam logic [31:0] RWP_UNLOCK_ADDR   = 32'h5000_0100;
  localparam logic [31:0] RWP_PERIPH_RST    = 32'h5000_0008;
  localparam logic [31:0] RWP_BROWNOUT      = 32'h5000_0018;
  localparam logic [31:0] RWP_POR_CTRL      = 32'h5000_0024;
  localparam logic [31:0] RWP_POWER_CTRL    = 32'h5000_0200;
  localparam logic [31:0] RWP_PCLK_EN       = 32'h5000_0208;
  localparam logic [31:0] RWP_CLKSEL_A      = 32'h5000_0210;
  localparam logic [31:0] RWP_CLKSEL_B      = 32'h5000_0214;
  localparam logic [31:0] RWP_FLASH_PROG    = 32'h5000_c000;
  localparam logic [31:0] RWP_WDOG_CTRL     = 32'h4000_4000;
  localparam logic [31:0] RWP_FLASH_TIMING  = 32'h5000_c018;

  // Partly guarded registers: bits left writable while locked (power) or guarded bits (clock enable, select B).
  localparam logic [31:0] RWP_POWER_FREE    = 32'h0000_0040;
  localparam logic [31:0] RWP_PCLK_GUARD    = 32'h0000_0001;
  localparam logic [31:0] RWP_CLKSEL_B_GUARD = 32'h0000_0003;

  localparam logic [1:0]  RWP_RESP_OKAY     = 2'b00;
  localparam logic [1:0]  RWP_RESP_SLVERR   = 2'b10;

  typedef enum logic [1:0] {
    RWP_IDLE  = 2'b00,
    RWP_GOT1  = 2'b01,
    RWP_GOT2  = 2'b11
  } rwp_seq_t;

  // One write seen on the system bus, for the guard to filter.
  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0]  strb;
  } rwp_sys_wr_t;

endpackage

/* verilog/rwp_lock.sv */
// Register write-protection lock: key sequence tracker, lock register on
// AXI4-Lite, and a filter that masks writes to guarded system registers.
// Assumes the system bus presents each write once, as a one-cycle strobe,
// and that the downstream registers apply the filtered byte mask it returns.
//
// Notes on behaviour
// - Locked from reset until key sequence completes.
// - Keys 59h, 16h, 88h in order.
// - Wrong value or foreign write aborts sequence.
// - Third correct key sets unlocked flag.
// - Bit 0 reads unlocked status.
// - Any lock-register write with byte lane 0 enabled relocks while unlocked.
// - Locked writes to guarded bits are discarded only in wholly guarded lanes; in partly guarded lanes they write 0.
// - Key field write-only; flag read-only.
// - Reset, brown-out, power-on control fully guarded.
// - Power control guarded except bit 6.
// - Clock enable register guards bit 0 only.
// - Clock select A fully guarded.
// - Clock select B guards bits 1..0.
// - Flash control, watchdog, flash timing guarded.
`timescale 1ns/1ps
`default_nettype none

module rwp_lock
  import rwp_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // Clock, reset and enable
  input  wire logic              clock,
  input  wire logic              resetn,
  input  wire logic              clk_en,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0] s_awaddr,
  input  wire logic              s_awvalid,
  output logic                   s_awready,
  input  wire logic [31:0]       s_wdata,
  input  wire logic [3:0]        s_wstrb,
  input  wire logic              s_wvalid,
  output logic                   s_wready,
  output logic [1:0]             s_bresp,
  output logic                   s_bvalid,
  input  wire logic              s_bready,
  input  wire logic [ADDR_W-1:0] s_araddr,
  input  wire logic              s_arvalid,
  output logic                   s_arready,
  output logic [31:0]            s_rdata,
  output logic [1:0]             s_rresp,
  output logic                   s_rvalid,
  input  wire logic              s_rready,
  // System bus write monitor and filtered write
  input  wire rwp_sys_wr_t       sys_wr,
  output rwp_sys_wr_t            sys_wr_out,
  // Lock status
  output logic                   unlocked
);

  // The lock word sits at 0x100, so the window needs at least nine bits.
  if (ADDR_W < 9 || ADDR_W > 32) begin : g_bad_addr_w
    $error("rwp_lock: ADDR_W must lie in 9..32");
  end

  // Lock offset brought to the width of the bus window.
  localparam logic [ADDR_W-1:0] LOCK_OFS = ADDR_W'(RWP_UNLOCK_OFS);

  logic              aw_held_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic              w_held_reg;
  logic [31:0]       w_data_reg;
  logic [3:0]        w_strb_reg;
  logic              ar_pend_reg;
  logic              unlocked_reg;
  rwp_seq_t          seq_reg;
  logic              wr_fire;
  logic              wr_hit;
  logic              key_wr;
  logic [7:0]        key_byte;
  logic              foreign_wr;
  logic [31:0]       guard_mask;
  logic [31:0]       keep_mask;
  logic [3:0]        keep_strb;
  logic              key0_ok;
  logic              key1_ok;
  logic              key2_ok;

  assign unlocked   = unlocked_reg;
  assign wr_fire    = aw_held_reg && w_held_reg && !s_bvalid;
  assign wr_hit     = (aw_addr_reg[ADDR_W-1:2] == LOCK_OFS[ADDR_W-1:2]);
  // A write that leaves the low byte lane off carries no key at all.
  assign key_wr     = wr_fire && wr_hit && w_strb_reg[0];
  assign key_byte   = w_data_reg[7:0];
  assign key0_ok    = (key_byte == RWP_KEY0);
  assign key1_ok    = (key_byte == RWP_KEY1);
  assign key2_ok    = (key_byte == RWP_KEY2);
  // A system write elsewhere breaks a half-entered sequence.
  assign foreign_wr = sys_wr.valid && (sys_wr.addr != RWP_UNLOCK_ADDR);

  // Write address and data channels are captured independently.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= '0;
      s_awready   <= 1'b0;
    end else if (clk_en) begin
      s_awready <= !aw_held_reg && !(s_awvalid && s_awready);
      if (s_awvalid && s_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_awaddr;
        s_awready   <= 1'b0;
      end else if (wr_fire) begin
        aw_held_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      w_held_reg <= 1'b0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
      s_wready   <= 1'b0;
    end else if (clk_en) begin
      s_wready <= !w_held_reg && !(s_wvalid && s_wready);
      if (s_wvalid && s_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_wdata;
        w_strb_reg <= s_wstrb;
        s_wready   <= 1'b0;
      end else if (wr_fire) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  // Write response; unmapped addresses answer SLVERR.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_bvalid <= 1'b0;
      s_bresp  <= RWP_RESP_OKAY;
    end else if (clk_en) begin
      if (wr_fire) begin
        s_bvalid <= 1'b1;
        s_bresp  <= wr_hit ? RWP_RESP_OKAY : RWP_RESP_SLVERR;
      end else if (s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  // Read channel: one read at a time, answer the cycle after acceptance.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_arready   <= 1'b0;
      ar_pend_reg <= 1'b0;
      s_rvalid    <= 1'b0;
      s_rdata     <= RWP_UNLOCK_RESET;
      s_rresp     <= RWP_RESP_OKAY;
    end else if (clk_en) begin
      s_arready <= !ar_pend_reg && !s_rvalid && !(s_arvalid && s_arready);
      if (s_arvalid && s_arready) begin
        s_arready   <= 1'b0;
        ar_pend_reg <= 1'b1;
        s_rvalid    <= 1'b1;
        s_rdata     <= '0;
        if (s_araddr[ADDR_W-1:2] == LOCK_OFS[ADDR_W-1:2]) begin
          // The key field never reads back; only the status shows.
          s_rdata[RWP_FLAG_BIT] <= unlocked_reg;
          s_rresp               <= RWP_RESP_OKAY;
        end else begin
          s_rresp <= RWP_RESP_SLVERR;
        end
      end else if (s_rvalid && s_rready) begin
        s_rvalid    <= 1'b0;
        ar_pend_reg <= 1'b0;
      end
    end
  end

  // Key sequence tracker and lock flag.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      seq_reg      <= RWP_IDLE;
      unlocked_reg <= 1'b0;
    end else if (clk_en) begin
      if (key_wr && unlocked_reg) begin
        unlocked_reg <= 1'b0;
        seq_reg      <= RWP_IDLE;
      end else if (key_wr) begin
        // A wrong byte always drops back to idle, even when it equals the
        // first key; software must then start the sequence again.
        case (seq_reg)
          RWP_IDLE: begin
            seq_reg <= key0_ok ? RWP_GOT1 : RWP_IDLE;
          end
          RWP_GOT1: begin
            seq_reg <= key1_ok ? RWP_GOT2 : RWP_IDLE;
          end
          RWP_GOT2: begin
            seq_reg <= RWP_IDLE;
            if (key2_ok)
              unlocked_reg <= 1'b1;
          end
          default: begin
            seq_reg <= RWP_IDLE;
          end
        endcase
      end else if (foreign_wr || (wr_fire && !wr_hit)) begin
        seq_reg <= RWP_IDLE;
      end
    end
  end

  // Guard table: one entry per protected register and the bits it guards.
  // Addresses are matched in full, so aliases of a guarded register pass.
  localparam int          N_GUARD = 10;
  localparam logic [31:0] GUARD_ADDR [N_GUARD] = '{
    RWP_PERIPH_RST,
    RWP_BROWNOUT,
    RWP_POR_CTRL,
    RWP_POWER_CTRL,
    RWP_PCLK_EN,
    RWP_CLKSEL_A,
    RWP_CLKSEL_B,
    RWP_FLASH_PROG,
    RWP_WDOG_CTRL,
    RWP_FLASH_TIMING
  };
  localparam logic [31:0] GUARD_BITS [N_GUARD] = '{
    32'hffff_ffff,
    32'hffff_ffff,
    32'hffff_ffff,
    ~RWP_POWER_FREE,
    RWP_PCLK_GUARD,
    32'hffff_ffff,
    RWP_CLKSEL_B_GUARD,
    32'hffff_ffff,
    32'hffff_ffff,
    32'hffff_ffff
  };

  logic [N_GUARD-1:0] guard_hit;
  logic [31:0]        guard_sel [N_GUARD];

  genvar gi;
  for (gi = 0; gi < N_GUARD; gi++) begin : g_guard
    assign guard_hit[gi] = (sys_wr.addr == GUARD_ADDR[gi]);
    assign guard_sel[gi] = guard_hit[gi] ? GUARD_BITS[gi] : 32'h0;
  end

  // Bits of the addressed register that the lock guards.
  always_comb begin
    guard_mask = 32'h0;
    for (int i = 0; i < N_GUARD; i++) begin
      guard_mask = guard_mask | guard_sel[i];
    end
    keep_mask = unlocked_reg ? 32'hffff_ffff : ~guard_mask;
  end

  // A byte lane stays enabled while any bit in it may still change; the
  // partly guarded lanes rely on the masked data bits instead.
  genvar gb;
  for (gb = 0; gb < 4; gb++) begin : g_strb
    assign keep_strb[gb] = |keep_mask[8*gb +: 8];
  end

  // The filtered write comes one cycle later, with guarded bits stripped
  // from the data and the byte strobes cleared for lanes that are wholly guarded.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sys_wr_out <= '0;
    end else if (clk_en) begin
      sys_wr_out.valid <= sys_wr.valid;
      sys_wr_out.addr  <= sys_wr.addr;
      sys_wr_out.data  <= sys_wr.data & keep_mask;
      sys_wr_out.strb  <= sys_wr.strb & keep_strb;
    end
  end

endmodule

`default_nettype wire

/* verification/rwp_lock_props.sv */
// Checker for the write-protection lock, bound to every rwp_lock.
// Sees only the lock's ports; one clock domain, reset active low.
`timescale 1ns/1ps
`default_nettype none

module rwp_lock_props
  import rwp_pkg::*;
(
  // Clock and reset
  input wire logic        clock,
  input wire logic        resetn,
  input wire logic        clk_en,
  // Observed outputs and system writes
  input wire logic        s_bvalid,
  input wire logic        s_rvalid,
  input wire logic [31:0] s_rdata,
  input wire rwp_sys_wr_t sys_wr,
  input wire rwp_sys_wr_t sys_wr_out,
  input wire logic        unlocked
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  // A system write sampled while protection is engaged.
  wire logic lk = sys_wr.valid && clk_en && !unlocked;

  property p_open; $rose(unlocked) |-> $rose(s_bvalid); endproperty
  a_open: assert property (p_open) else $error("opened without write");
  property p_close; $fell(unlocked) |-> $rose(s_bvalid); endproperty
  a_close: assert property (p_close) else $error("closed without write");
  property p_read;
    $rose(s_rvalid) |-> s_rdata == {31'h0, $past(unlocked)};
  endproperty
  a_read: assert property (p_read) else $error("bad status read");
  property p_full;
    lk && sys_wr.addr == RWP_PERIPH_RST |=> sys_wr_out.data == 32'h0;
  endproperty
  a_full: assert property (p_full) else $error("guarded write leaked");
  property p_pwr;
    lk && sys_wr.addr == RWP_POWER_CTRL
      |=> sys_wr_out.data == ($past(sys_wr.data) & RWP_POWER_FREE);
  endproperty
  a_pwr: assert property (p_pwr) else $error("power mask wrong");
  property p_pclk;
    lk && sys_wr.addr == RWP_PCLK_EN
      |=> sys_wr_out.data == ($past(sys_wr.data) & ~RWP_PCLK_GUARD);
  endproperty
  a_pclk: assert property (p_pclk) else $error("clock enable mask wrong");
  property p_selb;
    lk && sys_wr.addr == RWP_CLKSEL_B
      |=> sys_wr_out.data == ($past(sys_wr.data) & ~RWP_CLKSEL_B_GUARD);
  endproperty
  a_selb: assert property (p_selb) else $error("select mask wrong");
  property p_pass;
    sys_wr.valid && clk_en && unlocked
      |=> sys_wr_out.valid && sys_wr_out.data == $past(sys_wr.data);
  endproperty
  a_pass: assert property (p_pass) else $error("open write altered");

  c_open: cover property ($rose(unlocked));
  c_close: cover property ($fell(unlocked));
  c_mask: cover property (lk ##1 sys_wr_out.valid);
endmodule

bind rwp_lock rwp_lock_props u_props (.*);

`default_nettype wire

/* verification/tb.sv */
// Self-checking bench for the write-protection lock.
// Drives the AXI4-Lite slave and the system write monitor directly.
`timescale 1ns/1ps
`default_nettype none

module tb
  import rwp_pkg::*;
;
  logic        clock = 1'h0, resetn = 1'h0, clk_en = 1'h1;
  logic [11:0] s_awaddr = 12'h0, s_araddr = 12'h0;
  logic [31:0] s_wdata = 32'h0, s_rdata;
  logic [3:0]  s_wstrb = 4'hf;
  logic        s_awvalid = 1'h0, s_wvalid = 1'h0, s_bready = 1'h0;
  logic        s_arvalid = 1'h0, s_rready = 1'h0;
  logic        s_awready, s_wready, s_arready, s_bvalid, s_rvalid, unlocked;
  logic [1:0]  s_bresp, s_rresp;
  rwp_sys_wr_t sys_wr = '0, sys_wr_out;
  logic [31:0] exp_q[$];
  int          n_errors = 0, n_tests = 0, cyc = 0;
  // The last entry is outside the guarded set and must pass untouched.
  logic [31:0] ga[11] = '{RWP_PERIPH_RST, RWP_BROWNOUT, RWP_POR_CTRL,
    RWP_POWER_CTRL, RWP_PCLK_EN, RWP_CLKSEL_A, RWP_CLKSEL_B, RWP_FLASH_PROG,
    RWP_WDOG_CTRL, RWP_FLASH_TIMING, 32'h5000_0050};

  rwp_lock DUT (.*);

  always #5 clock = ~clock;

  function automatic logic [31:0] fm(logic [31:0] a);
    if (a == RWP_POWER_CTRL) return RWP_POWER_FREE;
    if (a == RWP_PCLK_EN) return ~RWP_PCLK_GUARD;
    if (a == RWP_CLKSEL_B) return ~RWP_CLKSEL_B_GUARD;
    return a == 32'h5000_0050 ? 32'hffff_ffff : 32'h0;
  endfunction

  task automatic conclude();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      n_errors++;
      $display("FAIL %s exp %h seen %h", n, e, s);
    end
  endtask

  task automatic pop(string n, logic [31:0] s);
    chk(n, s, exp_q.size() ? exp_q.pop_front() : 32'hx);
  endtask

  // Results are compared in arrival order; the drivers run one at a time.
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (s_bvalid === 1'h1 && s_bready) pop("bresp", 32'(s_bresp));
    if (s_rvalid === 1'h1 && s_rready) pop("rdata", s_rdata);
    if (sys_wr_out.valid === 1'h1) pop("sys", sys_wr_out.data);
    if (cyc == 4000) begin
      n_errors++;
      conclude();
    end
  end

  task automatic axw(logic [11:0] a, logic [31:0] d);
    exp_q.push_back(32'(a == RWP_UNLOCK_OFS ? RWP_RESP_OKAY : RWP_RESP_SLVERR));
    @(posedge clock);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'h1;
    s_wvalid <= 1'h1;
    s_bready <= 1'h1;
    do begin
      @(posedge clock);
      if (s_awready) s_awvalid <= 1'h0;
      if (s_wready) s_wvalid <= 1'h0;
    end while (!s_bvalid);
    s_bready <= 1'h0;
  endtask

  task automatic axr(logic [31:0] e);
    exp_q.push_back(e);
    @(posedge clock);
    s_araddr <= RWP_UNLOCK_OFS;
    s_arvalid <= 1'h1;
    s_rready <= 1'h1;
    do @(posedge clock); while (!s_arready);
    s_arvalid <= 1'h0;
    do @(posedge clock); while (!s_rvalid);
    s_rready <= 1'h0;
  endtask

  task automatic sw(logic [31:0] a, logic [31:0] m);
    logic [31:0] d;
    d = $urandom;
    exp_q.push_back(d & m);
    @(posedge clock);
    sys_wr <= '{1'h1, a, d, 4'hf};
    @(posedge clock);
    sys_wr <= '0;
  endtask

  task automatic key(logic [7:0] k);
    axw(RWP_UNLOCK_OFS, 32'(k));
  endtask

  initial begin
    void'($urandom(86324));
    repeat (3) @(posedge clock);
    resetn <= 1'h1;
    repeat (2) @(posedge clock);
    axr(32'h0);
    foreach (ga[i]) sw(ga[i], fm(ga[i]));
    $display("locked writes done");
    key(RWP_KEY0);
    key(RWP_KEY1);
    key(RWP_KEY2);
    axr(32'h1);
    foreach (ga[i]) sw(ga[i], 32'hffff_ffff);
    axw(RWP_UNLOCK_OFS, $urandom);
    axr(32'h0);
    axw(RWP_UNLOCK_OFS, 32'h1);
    axr(32'h0);
    $display("unlock and relock done");
    key(RWP_KEY1);
    key(RWP_KEY0);
    key(RWP_KEY2);
    axr(32'h0);
    key(RWP_KEY0);
    key(RWP_KEY1);
    axw(12'h104, $urandom);
    key(RWP_KEY2);
    axr(32'h0);
    key(RWP_KEY0);
    sw(RWP_PERIPH_RST, 32'h0);
    key(RWP_KEY1);
    key(RWP_KEY2);
    axr(32'h0);
    key(RWP_KEY0);
    key(RWP_KEY1);
    key(RWP_KEY2);
    axr(32'h1);
    $display("abort and restart done");
    clk_en <= 1'h0;
    sys_wr <= '{1'h1, RWP_PERIPH_RST, 32'hffff_ffff, 4'hf};
    repeat (3) @(posedge clock);
    clk_en <= 1'h1;
    sys_wr <= '0;
    @(posedge clock);
    chk("freeze", 32'(sys_wr_out.valid), 32'h0);
    chk("frozen flag", 32'(unlocked), 32'h1);
    $display("freeze done");
    conclude();
  end
endmodule

`default_nettype wire
